// [shared/aei_consts.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef AEI_CONSTS_SVH
`define AEI_CONSTS_SVH
`define AEI_OFS_CTRL 8'h02
`define AEI_OFS_EVA 8'h03
`define AEI_OFS_EVB 8'h04
`define AEI_OFS_MSKA 8'h05
`define AEI_OFS_MSKB 8'h06
`define AEI_OFS_IDCODE 8'h07
`define AEI_OFS_KTA 8'h08
`define AEI_OFS_KTB 8'h09
`define AEI_OFS_KINDA 8'h0a
`define AEI_OFS_KINDB 8'h0b
`define AEI_OFS_BTNA 8'h0c
`define AEI_OFS_BTNB 8'h0d
`define AEI_OFS_CARKIT 8'h0e
`define AEI_OFS_SWA 8'h13
`define AEI_OFS_SWB 8'h14
`define AEI_RST_CTRL 8'h1f
`define AEI_RST_MASK 8'h00
`define AEI_RST_KTA 8'h00
`define AEI_RST_KTB 8'h00
`define AEI_RST_SW 8'h00
`define AEI_CTRL_GMASK 0
`define AEI_CTRL_MANUAL 2
`define AEI_SWB_CHGDET 0
`define AEI_SWB_JIG 1
`define AEI_SWB_BOOT 2
`define AEI_EVA_ATTACH 0
`define AEI_EVA_DETACH 1
`define AEI_EVA_KEY 2
`define AEI_EVA_LKEY 3
`define AEI_EVA_LKEYREL 4
`define AEI_EVA_OVP 5
`define AEI_EVA_OCP 6
`define AEI_EVA_RECOV 7
`define AEI_EVB_RSVACC 0
`define AEI_EVB_ADCCHG 1
`define AEI_EVB_STUCK 2
`define AEI_EVB_STUCKREC 3
`define AEI_ID_OPEN 5'h1f
`define AEI_DCD_NS 10000
`define AEI_DCD_CYC ((`AEI_DCD_NS + 24) / 25)
`define AEI_UNMASK_NS 10000
`define AEI_UNMASK_CYC ((`AEI_UNMASK_NS + 24) / 25)
`define AEI_TICK_CYC 16'd4000
`endif

// [shared/aei_pkg.sv]
// Types of the accessory event interrupt logic
`default_nettype none
package aei_pkg;
    typedef enum logic [1:0] {KEY_IDLE, KEY_DOWN, KEY_LONG, KEY_STUCK} aei_key_t;
    typedef enum logic [1:0] {CHG_IDLE, CHG_DCD, CHG_TYPE, CHG_DONE} aei_chg_t;
endpackage
`default_nettype wire

// [hdl/aei_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module aei_sync (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } aei_sync_t;
    aei_sync_t st_r;
    aei_sync_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.q = st_r.s3;
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign dout = st_r.q;
endmodule
`default_nettype wire

// [hdl/aei_key_class.sv]
// Remote key press classifier: press, long press, stuck key
`timescale 1ns/1ps
`default_nettype none
module aei_key_class (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic keyDown,
    input wire logic [7:0] longTicks,
    input wire logic [7:0] stuckTicks,
    output logic evPress,
    output logic evLong,
    output logic evLongRel,
    output logic evStuck,
    output logic evStuckRec
);
    typedef struct packed {
        aei_pkg::aei_key_t state;
        logic [7:0] cnt;
        logic [4:0] ev;
    } aei_kc_t;
    aei_kc_t st_r;
    aei_kc_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ev = 5'h00;
        case (st_r.state)
            aei_pkg::KEY_IDLE:
            begin
                st_nxt.cnt = 8'h00;
                if (keyDown)
                begin
                    st_nxt.state = aei_pkg::KEY_DOWN;
                end
            end
            aei_pkg::KEY_DOWN:
            begin
                if (!keyDown)
                begin
                    st_nxt.ev[0] = 1'b1;
                    st_nxt.state = aei_pkg::KEY_IDLE;
                end
                else if (tick)
                begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                    if (st_r.cnt + 8'h01 >= longTicks)
                    begin
                        st_nxt.ev[1] = 1'b1;
                        st_nxt.state = aei_pkg::KEY_LONG;
                        st_nxt.cnt = 8'h00;
                    end
                end
            end
            aei_pkg::KEY_LONG:
            begin
                if (!keyDown)
                begin
                    st_nxt.ev[2] = 1'b1;
                    st_nxt.state = aei_pkg::KEY_IDLE;
                end
                else if (tick)
                begin
                    st_nxt.cnt = st_r.cnt + 8'h01;
                    if (st_r.cnt + 8'h01 >= stuckTicks)
                    begin
                        st_nxt.ev[3] = 1'b1;
                        st_nxt.state = aei_pkg::KEY_STUCK;
                    end
                end
            end
            aei_pkg::KEY_STUCK:
            begin
                if (!keyDown)
                begin
                    st_nxt.ev[4] = 1'b1;
                    st_nxt.state = aei_pkg::KEY_IDLE;
                end
            end
            default:
            begin
                st_nxt.state = aei_pkg::KEY_IDLE;
            end
        endcase
    end
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '{state: aei_pkg::KEY_IDLE, cnt: 8'h00, ev: 5'h00};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign evPress = st_r.ev[0];
    assign evLong = st_r.ev[1];
    assign evLongRel = st_r.ev[2];
    assign evStuck = st_r.ev[3];
    assign evStuckRec = st_r.ev[4];
endmodule
`default_nettype wire

// [hdl/aei_event_irq.sv]
// Accessory event and interrupt logic top level
`timescale 1ns/1ps
`default_nettype none
`include "aei_consts.svh"
module aei_event_irq (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic detValid,
    input wire logic [4:0] idCode,
    input wire logic [7:0] kindA,
    input wire logic [7:0] kindB,
    input wire logic [7:0] carKit,
    input wire logic [15:0] buttons,
    input wire logic keyDownPin,
    input wire logic connector_power_in,
    input wire logic overVoltPin,
    input wire logic overCurrPin,
    input wire logic dataContactPin,
    input wire logic usbChargerPin,
    output logic irq_out_n,
    output logic charger_found_n,
    output logic supplyConnect,
    output logic charger_power_out,
    output logic factory_fixture_out,
    output logic bootOut,
    output logic [7:0] switchSel
);
    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] evA;
        logic [7:0] evB;
        logic [7:0] mskA;
        logic [7:0] mskB;
        logic [4:0] idc;
        logic [7:0] ktA;
        logic [7:0] ktB;
        logic [7:0] kA;
        logic [7:0] kB;
        logic [15:0] btn;
        logic [7:0] ck;
        logic [7:0] swA;
        logic [7:0] swB;
        logic [7:0] rd;
        logic ovp;
        logic ocp;
        logic pend;
        logic irqN;
        logic chgN;
        logic sup;
        logic cpo;
        logic fix;
        logic boot;
        logic [7:0] sel;
        logic [15:0] unmCnt;
        logic [15:0] dcdCnt;
        logic [15:0] tickCnt;
        logic tick;
        logic attached;
        aei_pkg::aei_chg_t chg;
    } aei_top_t;
    aei_top_t st_r;
    aei_top_t st_nxt;
    logic keySync;
    logic ovSync;
    logic ocSync;
    logic dcSync;
    logic usbSync;
    logic vinSync;
    logic kPress;
    logic kLong;
    logic kLongRel;
    logic kStuck;
    logic kStuckRec;
    logic [7:0] setA;
    logic [7:0] setB;
    logic anyEv;
    // ------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------
    aei_sync uSyncKey (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(keyDownPin), .dout(keySync));
    aei_sync uSyncOv (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(overVoltPin), .dout(ovSync));
    aei_sync uSyncOc (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(overCurrPin), .dout(ocSync));
    aei_sync uSyncDc (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(dataContactPin), .dout(dcSync));
    aei_sync uSyncUsb (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(usbChargerPin), .dout(usbSync));
    aei_sync uSyncVin (.sys_clk(sys_clk), .sys_rst(sys_rst), .din(connector_power_in),
        .dout(vinSync));
    aei_key_class uKey (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .tick(st_r.tick),
        .keyDown(keySync),
        .longTicks(st_r.ktA),
        .stuckTicks(st_r.ktB),
        .evPress(kPress),
        .evLong(kLong),
        .evLongRel(kLongRel),
        .evStuck(kStuck),
        .evStuckRec(kStuckRec)
    );
    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        setA = 8'h00;
        setB = 8'h00;
        // Key timing tick
        st_nxt.tick = 1'b0;
        if (st_r.tickCnt == `AEI_TICK_CYC - 16'd1)
        begin
            st_nxt.tickCnt = 16'd0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.tickCnt = st_r.tickCnt + 16'd1;
        end
        // Detection results
        if (detValid)
        begin
            st_nxt.idc = idCode;
            st_nxt.kA = kindA;
            st_nxt.ck = carKit;
            st_nxt.kB = kindB;
            st_nxt.btn = buttons;
            if (idCode != st_r.idc)
            begin
                setB[`AEI_EVB_ADCCHG] = 1'b1;
            end
            if (idCode == `AEI_ID_OPEN && !vinSync)
            begin
                setA[`AEI_EVA_DETACH] = st_r.attached;
                st_nxt.attached = 1'b0;
            end
            else
            begin
                setA[`AEI_EVA_ATTACH] = !st_r.attached;
                st_nxt.attached = 1'b1;
                if (idCode >= 5'h0e && idCode <= 5'h12)
                begin
                    setB[`AEI_EVB_RSVACC] = 1'b1;
                end
            end
        end
        // Charger detection with data contact detection
        case (st_r.chg)
            aei_pkg::CHG_IDLE:
            begin
                st_nxt.dcdCnt = 16'd0;
                st_nxt.chgN = 1'b1;
                if (vinSync)
                begin
                    st_nxt.chg = aei_pkg::CHG_DCD;
                end
            end
            aei_pkg::CHG_DCD:
            begin
                if (!vinSync)
                begin
                    st_nxt.chg = aei_pkg::CHG_IDLE;
                end
                else if (dcSync || st_r.dcdCnt == 16'(`AEI_DCD_CYC))
                begin
                    st_nxt.chg = aei_pkg::CHG_TYPE;
                end
                else
                begin
                    st_nxt.dcdCnt = st_r.dcdCnt + 16'd1;
                end
            end
            aei_pkg::CHG_TYPE:
            begin
                st_nxt.chg = aei_pkg::CHG_DONE;
                st_nxt.chgN = !usbSync;
            end
            aei_pkg::CHG_DONE:
            begin
                if (!vinSync)
                begin
                    st_nxt.chg = aei_pkg::CHG_IDLE;
                end
            end
            default:
            begin
                st_nxt.chg = aei_pkg::CHG_IDLE;
            end
        endcase
        // Protection
        st_nxt.ovp = ovSync;
        st_nxt.ocp = ocSync && vinSync;
        if (ovSync && !st_r.ovp)
        begin
            setA[`AEI_EVA_OVP] = 1'b1;
        end
        if (ocSync && vinSync && !st_r.ocp)
        begin
            setA[`AEI_EVA_OCP] = 1'b1;
        end
        // Keys
        setA[`AEI_EVA_KEY] = kPress;
        setA[`AEI_EVA_LKEY] = kLong;
        setA[`AEI_EVA_LKEYREL] = kLongRel;
        setB[`AEI_EVB_STUCK] = kStuck;
        setB[`AEI_EVB_STUCKREC] = kStuckRec;
        // Read data and read-clear
        st_nxt.rd = 8'h00;
        if (regRd)
        begin
            case (regAddr)
                `AEI_OFS_CTRL: st_nxt.rd = st_r.ctrl;
                `AEI_OFS_EVA: st_nxt.rd = st_r.evA;
                `AEI_OFS_EVB: st_nxt.rd = st_r.evB;
                `AEI_OFS_MSKA: st_nxt.rd = st_r.mskA;
                `AEI_OFS_MSKB: st_nxt.rd = st_r.mskB;
                `AEI_OFS_IDCODE: st_nxt.rd = {3'h0, st_r.idc};
                `AEI_OFS_KTA: st_nxt.rd = st_r.ktA;
                `AEI_OFS_KTB: st_nxt.rd = st_r.ktB;
                `AEI_OFS_KINDA: st_nxt.rd = st_r.kA;
                `AEI_OFS_KINDB: st_nxt.rd = st_r.kB;
                `AEI_OFS_BTNA: st_nxt.rd = st_r.btn[7:0];
                `AEI_OFS_BTNB: st_nxt.rd = st_r.btn[15:8];
                `AEI_OFS_CARKIT: st_nxt.rd = st_r.ck;
                `AEI_OFS_SWA: st_nxt.rd = st_r.swA;
                `AEI_OFS_SWB: st_nxt.rd = st_r.swB;
                default: st_nxt.rd = 8'h00;
            endcase
            if (regAddr == `AEI_OFS_EVA)
            begin
                st_nxt.evA = 8'h00;
            end
            if (regAddr == `AEI_OFS_EVB)
            begin
                st_nxt.evB = 8'h00;
            end
        end
        // Fault removal clears fault flags, sets recovery
        if ((!ovSync && st_r.ovp) || (!st_nxt.ocp && st_r.ocp))
        begin
            st_nxt.evA[`AEI_EVA_OVP] = 1'b0;
            st_nxt.evA[`AEI_EVA_OCP] = 1'b0;
            setA[`AEI_EVA_RECOV] = 1'b1;
        end
        // Set wins over read clear
        st_nxt.evA = st_nxt.evA | (setA & ~st_r.mskA);
        st_nxt.evB = st_nxt.evB | (setB & ~st_r.mskB);
        anyEv = |(setA & ~st_r.mskA) || |(setB & ~st_r.mskB);
        // Register writes
        if (regWr)
        begin
            case (regAddr)
                `AEI_OFS_CTRL: st_nxt.ctrl = regWrData;
                `AEI_OFS_MSKA: st_nxt.mskA = regWrData;
                `AEI_OFS_MSKB: st_nxt.mskB = regWrData;
                `AEI_OFS_KTA: st_nxt.ktA = regWrData;
                `AEI_OFS_KTB: st_nxt.ktB = regWrData;
                `AEI_OFS_SWA: st_nxt.swA = regWrData;
                `AEI_OFS_SWB: st_nxt.swB = regWrData;
                default: st_nxt.ctrl = st_nxt.ctrl;
            endcase
        end
        // Interrupt line
        if (st_r.ctrl[`AEI_CTRL_GMASK])
        begin
            if (anyEv)
            begin
                st_nxt.pend = 1'b1;
            end
            if (!st_nxt.ctrl[`AEI_CTRL_GMASK])
            begin
                st_nxt.irqN = !(st_r.pend || anyEv);
                st_nxt.unmCnt = (st_r.pend || anyEv) ? 16'(`AEI_UNMASK_CYC) : 16'd0;
                st_nxt.pend = 1'b0;
            end
            else if (st_r.irqN == 1'b0 && regWr && regAddr == `AEI_OFS_CTRL)
            begin
                st_nxt.irqN = 1'b0;
            end
            else if (st_r.irqN)
            begin
                st_nxt.irqN = 1'b1;
            end
        end
        else
        begin
            if (st_r.unmCnt != 16'd0)
            begin
                st_nxt.unmCnt = st_r.unmCnt - 16'd1;
                if (st_r.unmCnt == 16'd1 && st_r.evA == 8'h00)
                begin
                    st_nxt.irqN = 1'b1;
                end
            end
            if (anyEv)
            begin
                st_nxt.irqN = 1'b0;
            end
            else if (regRd && regAddr == `AEI_OFS_EVA && st_r.unmCnt == 16'd0)
            begin
                st_nxt.irqN = 1'b1;
            end
            if (st_nxt.ctrl[`AEI_CTRL_GMASK])
            begin
                st_nxt.irqN = 1'b1;
                st_nxt.pend = 1'b0;
            end
        end
        // Switch configuration
        if (st_r.ctrl[`AEI_CTRL_MANUAL])
        begin
            st_nxt.sel = st_r.swA;
            st_nxt.fix = st_r.swB[`AEI_SWB_JIG];
            st_nxt.boot = st_r.swB[`AEI_SWB_BOOT];
            st_nxt.chgN = !st_r.swB[`AEI_SWB_CHGDET];
        end
        else
        begin
            st_nxt.sel = {3'h0, st_r.idc};
            st_nxt.fix = (st_r.idc >= 5'h18 && st_r.idc <= 5'h1d);
            st_nxt.boot = st_r.idc[0] && st_nxt.fix;
        end
        st_nxt.sup = vinSync && !ovSync;
        st_nxt.cpo = vinSync && !ovSync && !st_nxt.ocp;
    end
    // ------------------------------------------------
    // Registers
    // ------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.ctrl <= `AEI_RST_CTRL;
            st_r.mskA <= `AEI_RST_MASK;
            st_r.mskB <= `AEI_RST_MASK;
            st_r.ktA <= `AEI_RST_KTA;
            st_r.ktB <= `AEI_RST_KTB;
            st_r.swA <= `AEI_RST_SW;
            st_r.swB <= `AEI_RST_SW;
            st_r.idc <= `AEI_ID_OPEN;
            st_r.irqN <= 1'b0;
            st_r.chgN <= 1'b1;
            st_r.chg <= aei_pkg::CHG_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign regRdData = st_r.rd;
    assign irq_out_n = st_r.irqN;
    assign charger_found_n = st_r.chgN;
    assign supplyConnect = st_r.sup;
    assign charger_power_out = st_r.cpo;
    assign factory_fixture_out = st_r.fix;
    assign bootOut = st_r.boot;
    assign switchSel = st_r.sel;
endmodule
`default_nettype wire

// [verification/aei_cpu_model.sv]
// Processor model on the register port
`timescale 1ns/1ps
`default_nettype none
module aei_cpu_model (
    input wire logic sys_clk,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWr,
    output logic regRd,
    input wire logic [7:0] regRdData
);
    // ----------------
    // Bus cycles
    // ----------------
    initial
    begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // Idle lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        @(negedge sys_clk);
        d = regRdData;
        @(posedge sys_clk);
    endtask
    // Flags A first, then flags B
    task automatic service(output logic [7:0] fa, output logic [7:0] fb);
        rd(8'h03, fa);
        rd(8'h04, fb);
    endtask
endmodule
`default_nettype wire

// [verification/aei_event_irq_assertions.sv]
// Port checker for the accessory event interrupt logic
`timescale 1ns/1ps
`default_nettype none
module aei_event_irq_assertions (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic detValid,
    input wire logic [4:0] idCode,
    input wire logic [7:0] carKit,
    input wire logic connector_power_in,
    input wire logic overVoltPin,
    input wire logic overCurrPin,
    input wire logic irq_out_n,
    input wire logic supplyConnect,
    input wire logic charger_power_out,
    input wire logic factory_fixture_out
);
    // ----------------
    // Helper state
    // ----------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic manR;
    logic armR;
    logic gotR;
    logic [4:0] idR;
    logic [7:0] carR;
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            manR <= 1'b1;
            armR <= 1'b0;
            gotR <= 1'b0;
            idR <= 5'h00;
            carR <= 8'h00;
        end
        else
        begin
            if (regWr && regAddr == 8'h02)
            begin
                manR <= regWrData[2];
                armR <= armR | ~regWrData[0];
            end
            if (detValid)
            begin
                gotR <= 1'b1;
                idR <= idCode;
                carR <= carKit;
            end
        end
    end
    // ----------------
    // Properties
    // ----------------
    read_idle_a: assert property (
        !$past(regRd) |-> regRdData == 8'h00) else $error("read data outside slot");
    id_store_a: assert property (
        regRd && regAddr == 8'h07 && gotR && !detValid |=> regRdData == {3'h0, idR})
        else $error("id code readback wrong");
    car_store_a: assert property (
        regRd && regAddr == 8'h0e && gotR && !detValid |=> regRdData == carR)
        else $error("car kit readback wrong");
    ov_cut_a: assert property (
        overVoltPin [*8] |-> !supplyConnect) else $error("supply kept on over voltage");
    oc_cut_a: assert property (
        overCurrPin [*8] |-> !charger_power_out) else $error("charger kept on over current");
    no_vin_a: assert property (
        !connector_power_in [*8] |-> !charger_power_out && !supplyConnect)
        else $error("outputs on without supply");
    gmask_high_a: assert property (
        regWr && regAddr == 8'h02 && regWrData[0] && armR |-> ##[1:3] irq_out_n)
        else $error("interrupt low under global mask");
    fixture_out_a: assert property (
        regWr && regAddr == 8'h14 && manR |=> ##1 factory_fixture_out == $past(regWrData[1], 2))
        else $error("fixture output not from manual register");
    cover property (detValid);
    cover property ($rose(irq_out_n));
    cover property (regRd && regAddr == 8'h03);
endmodule
`default_nettype wire

// [verification/aei_event_irq_bench.sv]
// Self-checking bench for the accessory event interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "aei_consts.svh"
module aei_event_irq_bench;
    logic [7:0] regAddr, regWrData, regRdData, kindA, kindB, carKit, switchSel, fa, fb, v;
    logic [4:0] idCode;
    logic [15:0] buttons;
    logic sys_clk, sys_rst, regWr, regRd, detValid, keyDownPin, vin, ovPin, ocPin, dcPin, usbPin;
    logic irqN, chgN, supOn, chgOut, fixOut, bootOut;
    int nMismatch, samplesChecked, i;
    realtime t0;
    aei_cpu_model cpu (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
    aei_event_irq dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .detValid(detValid), .idCode(idCode), .kindA(kindA), .kindB(kindB), .carKit(carKit),
        .buttons(buttons), .keyDownPin(keyDownPin), .connector_power_in(vin),
        .overVoltPin(ovPin), .overCurrPin(ocPin), .dataContactPin(dcPin),
        .usbChargerPin(usbPin), .irq_out_n(irqN), .charger_found_n(chgN),
        .supplyConnect(supOn), .charger_power_out(chgOut), .factory_fixture_out(fixOut),
        .bootOut(bootOut), .switchSel(switchSel));
    // ----------------
    // Helpers
    // ----------------
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (nMismatch == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic waitIrq(input logic lvl, input int lim);
        for (int k = 0; k < lim && irqN !== lvl; k++)
            @(posedge sys_clk);
        if (irqN !== lvl)
        begin
            chk(irqN, lvl);
            final_report;
        end
    endtask
    task automatic detect(input logic [4:0] c);
        @(posedge sys_clk);
        idCode <= c;
        detValid <= 1'b1;
        @(posedge sys_clk);
        detValid <= 1'b0;
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_reset;
        chk(irqN, 1'b0);
        cpu.rd(8'h02, v);
        chk(v, 8'h1f);
        cpu.rd(8'h20, v);
        chk(v, 8'h00);
        cpu.wr(8'h08, 8'h02);
        cpu.wr(8'h09, 8'h01);
        cpu.rd(8'h08, v);
        chk(v, 8'h02);
        cpu.rd(8'h09, v);
        chk(v, 8'h01);
        cpu.wr(8'h02, 8'h1e);
        waitIrq(1'b1, 10);
    endtask
    task automatic t_attach;
        detect(5'h17);
        waitIrq(1'b0, 8);
        cpu.service(fa, fb);
        chk(fa, 8'h01);
        waitIrq(1'b1, 4);
        cpu.rd(8'h03, v);
        chk(v, 8'h00);
        cpu.rd(8'h07, v);
        chk(v, 8'h17);
        cpu.rd(8'h0a, v);
        chk(v, kindA);
        cpu.rd(8'h0e, v);
        chk(v, carKit);
        cpu.rd(8'h0b, v);
        chk(v, kindB);
        cpu.rd(8'h0c, v);
        chk(v, buttons[7:0]);
        cpu.rd(8'h0d, v);
        chk(v, buttons[15:8]);
    endtask
    task automatic t_masks;
        cpu.wr(8'h05, 8'h02);
        cpu.wr(8'h06, 8'h02);
        detect(5'h1f);
        repeat (10) @(posedge sys_clk);
        chk(irqN, 1'b1);
        cpu.rd(8'h04, v);
        chk(v, 8'h00);
        cpu.wr(8'h05, 8'h00);
        cpu.wr(8'h06, 8'h00);
        detect(5'h0e);
        waitIrq(1'b0, 8);
        cpu.service(fa, fb);
        chk(fb, 8'h03);
    endtask
    task automatic t_charger;
        cpu.wr(8'h02, 8'h1a);
        @(posedge sys_clk);
        vin <= 1'b1;
        repeat (50) @(posedge sys_clk);
        chk(chgN, 1'b1);
        dcPin <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk(chgN, 1'b0);
    endtask
    task automatic t_faults;
        for (i = 0; i < 2; i++)
        begin
            repeat (20) @(posedge sys_clk);
            cpu.service(fa, fb);
            ovPin <= (i == 0);
            ocPin <= (i == 1);
            waitIrq(1'b0, 12);
            cpu.service(fa, fb);
            chk(fa[5 + i], 1'b1);
            chk(i ? chgOut : supOn, 1'b0);
            ovPin <= 1'b0;
            ocPin <= 1'b0;
            waitIrq(1'b0, 12);
            cpu.service(fa, fb);
            chk(fa[7:5], 3'b100);
        end
    endtask
    task automatic t_gmask;
        repeat (20) @(posedge sys_clk);
        cpu.service(fa, fb);
        cpu.wr(8'h02, 8'h1b);
        detect(5'h17);
        repeat (10) @(posedge sys_clk);
        chk(irqN, 1'b1);
        cpu.wr(8'h02, 8'h1a);
        waitIrq(1'b0, 5);
        t0 = $realtime;
        repeat (100) @(posedge sys_clk);
        cpu.service(fa, fb);
        waitIrq(1'b1, 600);
        chk(int'(($realtime - t0) / 25.0) inside {[`AEI_UNMASK_CYC - 8:`AEI_UNMASK_CYC + 8]},
            1'b1);
    endtask
    task automatic t_manual;
        cpu.wr(8'h02, 8'h1e);
        cpu.wr(8'h13, 8'ha5);
        cpu.wr(8'h14, 8'h02);
        repeat (3) @(posedge sys_clk);
        chk(switchSel, 8'ha5);
        chk({fixOut, bootOut}, 2'b10);
        cpu.wr(8'h14, 8'h04);
        repeat (3) @(posedge sys_clk);
        chk({fixOut, bootOut}, 2'b01);
        cpu.rd(8'h14, v);
        chk(v, 8'h04);
        for (i = 0; i < 2; i++)
        begin
            keyDownPin <= 1'b1;
            repeat (i ? 12100 : 40) @(posedge sys_clk);
            keyDownPin <= 1'b0;
            repeat (12) @(posedge sys_clk);
            cpu.service(fa, fb);
            chk({fa, fb}, i ? 16'h080c : 16'h0400);
        end
    endtask
    initial
    begin
        sys_rst = 1'b1;
        detValid = 1'b0;
        idCode = 5'h00;
        kindA = 8'h04;
        kindB = 8'h20;
        carKit = 8'h02;
        buttons = 16'h0810;
        keyDownPin = 1'b0;
        vin = 1'b0;
        ovPin = 1'b0;
        ocPin = 1'b0;
        dcPin = 1'b0;
        usbPin = 1'b1;
        nMismatch = 0;
        samplesChecked = 0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_attach;
        t_masks;
        t_charger;
        t_faults;
        t_gmask;
        t_manual;
        final_report;
    end
endmodule
bind aei_event_irq aei_event_irq_assertions chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .detValid(detValid), .idCode(idCode), .carKit(carKit),
    .connector_power_in(connector_power_in), .overVoltPin(overVoltPin),
    .overCurrPin(overCurrPin), .irq_out_n(irq_out_n), .supplyConnect(supplyConnect),
    .charger_power_out(charger_power_out), .factory_fixture_out(factory_fixture_out));
`default_nettype wire
